// [rtl/fopin_ctrl.sv]
// fail-output / gpio pin control with hv measurement interlock, apb slave
// assumes pin inputs asynchronous; mode inputs from pclk-domain logic
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
// How it works
// - normal mode allows pin config and measurement writes; stop, sleep, restart and fail-safe keep their normal-mode values.
// - pin reported active means fail output driven by restart/fail-safe entry.
// - while measuring, fail output, its test and gpio unavailable; tries flag.
// - pin config writes rejected while measuring; stored value kept.
// - measurement refused while fail output configured; error flag set.
// - measuring disables wake pulls and blocks the internal wake signal.
// - wake pull writes stored while measuring but not applied.
// - measuring stops wake detection and level status updates.
// - sleep request with pin wake only source while measuring goes restart.
// - wake input level change qualified after 16 us filter.
// - overcurrent or restart/fail-safe entry forces switch config to off.
module fopin_ctrl #(
  parameter int FILT = fopin_pkg::FILT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire fopin_pkg::fopin_mode_t chip_mode,
  input wire logic failure_entry,
  input wire logic other_wake_src,
  input wire logic pin_level_in,
  input wire logic overcurrent_in,
  output fopin_pkg::fopin_pin_t pin_out,
  output logic pin_active,
  output logic wake_to_chip,
  output logic go_restart,
  output logic irq
);
  // ==========================================================
  // registers
  logic [2:0] pin_cfg;
  logic fail_output_test_on;
  logic hv_measure_enable;
  logic [1:0] wake_pull_config;
  logic [1:0] pull_applied;
  logic wake_level_status;
  logic wake_event_status;
  logic fail_active;
  localparam int IRQ_W = fopin_pkg::IRQ_W;
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] ev;
  fopin_pkg::fopin_mode_t mode_q;
  logic lvl_sync;
  logic oc_sync;
  logic filt_q;
  logic filt_chg;
  logic wr;
  logic rd;
  logic cmd_err;
  logic sleep_req;
  logic sleep_block;
  logic stat_wr;
  logic cfg_wr_try;
  logic meas_wr_try;
  logic cfg_accept;
  logic [2:0] next_cfg;

  function automatic logic is_switch(input logic [2:0] c);
    is_switch = (c == fopin_pkg::CFG_LS) || (c == fopin_pkg::CFG_HS) ||
                (c == fopin_pkg::CFG_HS_CS);
  endfunction : is_switch

  function automatic logic is_func(input logic [2:0] c);
    is_func = (c != fopin_pkg::CFG_OFF);
  endfunction : is_func

  assign wr = psel && penable && pwrite;
  assign rd = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  // ==========================================================
  // pin input crossing and wake filter
  fopin_sync u_lvl (
    .pclk(pclk), .presetn(presetn), .d(pin_level_in), .q(lvl_sync)
  );
  fopin_sync u_oc (
    .pclk(pclk), .presetn(presetn), .d(overcurrent_in), .q(oc_sync)
  );
  fopin_filter #(.CYC(FILT)) u_filt (
    .pclk(pclk), .presetn(presetn),
    .en(pin_cfg == fopin_pkg::CFG_WAKE && !hv_measure_enable),
    .d(lvl_sync), .q(filt_q), .change(filt_chg)
  );

  // ==========================================================
  // interlock decisions
  assign cfg_wr_try = wr && paddr == fopin_pkg::OFF_PIN_CFG;
  assign meas_wr_try = wr && paddr == fopin_pkg::OFF_MEAS && pwdata[0]
                       && !hv_measure_enable;
  assign sleep_req = wr && paddr == fopin_pkg::OFF_MODE_REQ && pwdata[0];
  assign sleep_block = sleep_req && hv_measure_enable &&
                       pin_cfg == fopin_pkg::CFG_WAKE && !other_wake_src;
  assign stat_wr = wr && paddr == fopin_pkg::OFF_STATUS;
  assign cfg_accept = cfg_wr_try && !hv_measure_enable &&
                      chip_mode == fopin_pkg::FOPIN_NORMAL;
  assign cmd_err =
    (cfg_wr_try && hv_measure_enable) ||
    (meas_wr_try && pin_cfg == fopin_pkg::CFG_FAIL_OUT) ||
    sleep_block;
  assign go_restart = sleep_block;

  // ==========================================================
  // pin configuration
  always_comb
  begin
    next_cfg = pin_cfg;
    if (cfg_accept)
      next_cfg = pwdata[2:0];
    if (is_switch(pin_cfg) && (oc_sync || failure_entry))
      next_cfg = fopin_pkg::CFG_OFF;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pin_cfg <= fopin_pkg::CFG_RESET;
      fail_output_test_on <= 1'b0;
    end
    else
    begin
      pin_cfg <= next_cfg;
      if (cfg_accept)
        fail_output_test_on <= pwdata[fopin_pkg::CFG_TEST_BIT];
    end
  end

  // ==========================================================
  // measurement enable and wake pulls
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      hv_measure_enable <= 1'b0;
    else if (wr && paddr == fopin_pkg::OFF_MEAS &&
             chip_mode == fopin_pkg::FOPIN_NORMAL)
    begin
      if (!pwdata[0] || pin_cfg != fopin_pkg::CFG_FAIL_OUT)
        hv_measure_enable <= pwdata[0];
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_pull_config <= fopin_pkg::PULL_RESET;
      pull_applied <= fopin_pkg::PULL_RESET;
    end
    else
    begin
      if (wr && paddr == fopin_pkg::OFF_WAKE_PULL)
        wake_pull_config <= pwdata[1:0];
      if (!hv_measure_enable)
        pull_applied <= wake_pull_config;
    end
  end

  // ==========================================================
  // wake status and fail output activation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wake_level_status <= 1'b0;
      wake_event_status <= 1'b0;
      fail_active <= 1'b0;
      mode_q <= fopin_pkg::FOPIN_NORMAL;
    end
    else
    begin
      mode_q <= chip_mode;
      if (!hv_measure_enable)
        wake_level_status <= filt_q;
      if (filt_chg && !hv_measure_enable)
        wake_event_status <= 1'b1;
      else if (stat_wr && pwdata[1])
        wake_event_status <= 1'b0;
      if (failure_entry && pin_cfg == fopin_pkg::CFG_FAIL_OUT &&
          !hv_measure_enable)
        fail_active <= 1'b1;
      else if (stat_wr && pwdata[0])
        fail_active <= 1'b0;
    end
  end

  // ==========================================================
  // pin drive
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_out <= '0;
    else
    begin
      pin_out.fail_drive <= !hv_measure_enable &&
        pin_cfg == fopin_pkg::CFG_FAIL_OUT &&
        (fail_active || fail_output_test_on);
      pin_out.ls_on <= !hv_measure_enable && pin_cfg == fopin_pkg::CFG_LS;
      pin_out.hs_on <= !hv_measure_enable &&
        (pin_cfg == fopin_pkg::CFG_HS || pin_cfg == fopin_pkg::CFG_HS_CS);
      pin_out.pull_up <= !hv_measure_enable && pull_applied == 2'h2;
      pin_out.pull_down <= !hv_measure_enable && pull_applied == 2'h1;
      pin_out.meas_route <= hv_measure_enable;
    end
  end

  // ==========================================================
  // failure report, test drive excluded
  // failure-caused drive only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pin_active <= 1'b0;
    else
      pin_active <= !hv_measure_enable &&
        pin_cfg == fopin_pkg::CFG_FAIL_OUT && fail_active;
  end
  assign wake_to_chip = filt_chg && !hv_measure_enable &&
                        is_func(pin_cfg) && mode_q != fopin_pkg::FOPIN_NORMAL;

  // ==========================================================
  // interrupts: set wins over write-one clear
  always_comb
  begin
    ev = '0;
    ev[fopin_pkg::IRQ_CMD_ERR] = cmd_err;
    ev[fopin_pkg::IRQ_WAKE] = filt_chg && !hv_measure_enable;
    ev[fopin_pkg::IRQ_OC] = oc_sync && is_switch(pin_cfg);
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      irq_stat <= '0;
      irq_mask <= '0;
    end
    else
    begin
      if (wr && paddr == fopin_pkg::OFF_IRQ_STAT)
        irq_stat <= (irq_stat & ~pwdata[IRQ_W-1:0]) | ev;
      else
        irq_stat <= irq_stat | ev;
      if (wr && paddr == fopin_pkg::OFF_IRQ_MASK)
        irq_mask <= pwdata[IRQ_W-1:0];
    end
  end
  // a set mask bit hides its event
  assign irq = |(irq_stat & ~irq_mask);

  // ==========================================================
  // read data, captured in setup phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (rd)
    begin
      if (paddr == fopin_pkg::OFF_PIN_CFG)
        prdata <= {28'h0, fail_output_test_on, pin_cfg};
      else if (paddr == fopin_pkg::OFF_MEAS)
        prdata <= {31'h0, hv_measure_enable};
      else if (paddr == fopin_pkg::OFF_WAKE_PULL)
        prdata <= {30'h0, wake_pull_config};
      else if (paddr == fopin_pkg::OFF_STATUS)
        prdata <= {29'h0, wake_level_status, wake_event_status,
                   fail_active};
      else if (paddr == fopin_pkg::OFF_IRQ_STAT)
        prdata <= {29'h0, irq_stat};
      else if (paddr == fopin_pkg::OFF_IRQ_MASK)
        prdata <= {29'h0, irq_mask};
      else
        prdata <= 32'h0;
    end
  end
endmodule : fopin_ctrl

// [rtl/fopin_filter.sv]
// level filter: output follows input after it holds for CYC cycles
// assumes a synchronised input; reference level starts low
`timescale 1ns/1ps
module fopin_filter #(
  parameter int CYC = fopin_pkg::FILT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic d,
  output logic q,
  output logic change
);
  localparam int CW = $clog2(CYC + 1);
  logic [CW-1:0] cnt;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= '0;
      q <= 1'b0;
      change <= 1'b0;
    end
    else
    begin
      change <= 1'b0;
      if (!en || d == q)
        cnt <= '0;
      else if (cnt == CW'(CYC - 1))
      begin
        cnt <= '0;
        q <= d;
        change <= 1'b1;
      end
      else
        cnt <= cnt + 1'b1;
    end
  end
endmodule : fopin_filter

// [rtl/fopin_pkg.sv]
// package for the fail-output pin block: apb map, field layout, timing
// assumes a single pclk domain at 20 MHz
package fopin_pkg;
  // ==========================================================
  // apb register byte offsets
  localparam logic [7:0] OFF_PIN_CFG = 8'h00;
  localparam logic [7:0] OFF_MEAS = 8'h04;
  localparam logic [7:0] OFF_WAKE_PULL = 8'h08;
  localparam logic [7:0] OFF_STATUS = 8'h0c;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h14;
  localparam logic [7:0] OFF_MODE_REQ = 8'h18;
  // ==========================================================
  // pin configuration codes (3 bits)
  localparam logic [2:0] CFG_FAIL_OUT = 3'h0;
  localparam logic [2:0] CFG_WAKE = 3'h1;
  localparam logic [2:0] CFG_HS_CS = 3'h3;
  localparam logic [2:0] CFG_OFF = 3'h4;
  localparam logic [2:0] CFG_LS = 3'h6;
  localparam logic [2:0] CFG_HS = 3'h7;
  localparam logic [2:0] CFG_RESET = CFG_FAIL_OUT;
  // ==========================================================
  // field positions
  localparam int CFG_TEST_BIT = 3;
  localparam int IRQ_CMD_ERR = 0;
  localparam int IRQ_WAKE = 1;
  localparam int IRQ_OC = 2;
  localparam int IRQ_W = 3;
  localparam logic [1:0] PULL_RESET = 2'h0;
  // ==========================================================
  // chip modes
  typedef enum logic [2:0] {
    FOPIN_NORMAL, FOPIN_STOP, FOPIN_SLEEP, FOPIN_RESTART, FOPIN_FAILSAFE
  } fopin_mode_t;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 20000000;
  localparam int FILT_US = 16;
  localparam int FILT_CYC = (FILT_US * (CLK_HZ / 1000000) > 0) ?
                            FILT_US * (CLK_HZ / 1000000) : 1;
  // ==========================================================
  // pin-side carrier
  typedef struct packed {
    logic fail_drive;
    logic ls_on;
    logic hs_on;
    logic pull_up;
    logic pull_down;
    logic meas_route;
  } fopin_pin_t;
endpackage : fopin_pkg

// [rtl/fopin_sync.sv]
// two-flop synchroniser for one level
// assumes d comes from outside the pclk domain
`timescale 1ns/1ps
module fopin_sync
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic d,
  output logic q
);
  logic meta;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta <= 1'b0;
      q <= 1'b0;
    end
    else
    begin
      meta <= d;
      q <= meta;
    end
  end
endmodule : fopin_sync

// [verification/fopin_host.sv]
// host model: apb master issuing configuration transfers
// assumes tasks are called just after a rising edge of pclk
`timescale 1ns/1ps
module fopin_host
(
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial
  begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
    @(posedge pclk);
  endtask : xfer
  task automatic meas_on(input logic [2:0] cfg);
    logic [31:0] q;
    xfer(1'b1, fopin_pkg::OFF_PIN_CFG, {29'h0, cfg}, q);
    xfer(1'b1, fopin_pkg::OFF_MEAS, 32'h1, q);
  endtask : meas_on
endmodule : fopin_host

// [verification/fopin_monitor.sv]
// checker for the fail-output pin block, sees the top ports only
// assumes it is bound into fopin_ctrl
`timescale 1ns/1ps
module fopin_monitor #(
  parameter int FILT = fopin_pkg::FILT_CYC
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire fopin_pkg::fopin_mode_t chip_mode,
  input wire logic failure_entry,
  input wire logic other_wake_src,
  input wire logic pin_level_in,
  input wire logic overcurrent_in,
  input wire fopin_pkg::fopin_pin_t pin_out,
  input wire logic pin_active,
  input wire logic wake_to_chip,
  input wire logic go_restart,
  input wire logic irq
);
  // ==========================================================
  // sequences
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence sleep_req_s;
    psel && penable && pwrite && paddr == fopin_pkg::OFF_MODE_REQ && pwdata[0];
  endsequence
  sequence oc_hold_s;
    overcurrent_in [*6];
  endsequence
  sequence stop_pair_s;
    (chip_mode == fopin_pkg::FOPIN_STOP && !overcurrent_in)
      ##1 chip_mode == fopin_pkg::FOPIN_STOP;
  endsequence
  // ==========================================================
  // assertions
  pin_active_a: assert property (
    pin_active |-> pin_out.fail_drive) else $error("pin active wrong");
  meas_excl_a: assert property (
    pin_out.meas_route |-> !(pin_out.fail_drive || pin_out.ls_on ||
    pin_out.hs_on)) else $error("output active while measuring");
  pull_off_a: assert property (
    pin_out.meas_route |-> !pin_out.pull_up && !pin_out.pull_down)
    else $error("pull on while measuring");
  wake_block_a: assert property (
    pin_out.meas_route |-> !wake_to_chip) else $error("wake while measuring");
  restart_cause_a: assert property (
    go_restart |-> sleep_req_s and pin_out.meas_route && !other_wake_src)
    else $error("restart without cause");
  oc_off_a: assert property (
    oc_hold_s |-> !pin_out.ls_on && !pin_out.hs_on)
    else $error("switch on during overcurrent");
  fail_off_a: assert property (
    failure_entry |-> ##[1:3] !pin_out.ls_on && !pin_out.hs_on)
    else $error("switch on after failure");
  stop_hold_a: assert property (
    stop_pair_s |-> $stable(pin_out)) else $error("pin changed in stop");
endmodule : fopin_monitor

// [verification/tb_top.sv]
// self-checking bench for fopin_ctrl with a host model
// assumes short wake filter parameter for simulation
`timescale 1ns/1ps
module tb_top;
  logic pclk = 1'b0, presetn = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, seed = 32'h6ead, q;
  fopin_pkg::fopin_mode_t chip_mode = fopin_pkg::FOPIN_NORMAL;
  logic failure_entry = 0, other_wake_src = 0, pin_level_in = 0;
  logic overcurrent_in = 0, pin_active, wake_to_chip, go_restart, irq;
  logic seen_restart = 0;
  logic seen_wake = 0;
  fopin_pkg::fopin_pin_t pin_out;
  int n_mismatch = 0, total_checks = 0, cyc = 0;
  fopin_ctrl #(.FILT(4)) fopin_ctrl_i (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .chip_mode(chip_mode), .failure_entry(failure_entry),
    .other_wake_src(other_wake_src), .pin_level_in(pin_level_in),
    .overcurrent_in(overcurrent_in), .pin_out(pin_out),
    .pin_active(pin_active), .wake_to_chip(wake_to_chip),
    .go_restart(go_restart), .irq(irq));
  fopin_host fopin_host_i (.pclk(pclk), .prdata(prdata), .pready(pready),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata));
  always #25 pclk = ~pclk;
  always @(posedge pclk)
  begin
    seen_restart <= seen_restart | go_restart;
    seen_wake <= seen_wake | wake_to_chip;
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      give_verdict();
    end
  end
  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    fopin_host_i.xfer(1'b1, a, d, q);
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    fopin_host_i.xfer(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rd
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict
  // ==========================================================
  // main sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    wr(fopin_pkg::OFF_IRQ_MASK, 32'h0);
    rd("cfg reset", fopin_pkg::OFF_PIN_CFG, 32'h0);
    wr(fopin_pkg::OFF_MEAS, 32'h1);
    rd("meas refused", fopin_pkg::OFF_MEAS, 32'h0);
    rd("err flag", fopin_pkg::OFF_IRQ_STAT, 32'h1);
    chk("irq up", 1, irq);
    wr(fopin_pkg::OFF_IRQ_MASK, 32'h7);
    chk("irq masked", 0, irq);
    wr(fopin_pkg::OFF_IRQ_STAT, 32'h7);
    fopin_host_i.meas_on(fopin_pkg::CFG_WAKE);
    @(posedge pclk);
    chk("meas route", 1, pin_out.meas_route);
    wr(fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_LS});
    rd("cfg kept", fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_WAKE});
    rd("try flag", fopin_pkg::OFF_IRQ_STAT, 32'h1);
    repeat (3)
    begin
      seed = lfsr_next(seed);
      wr(fopin_pkg::OFF_WAKE_PULL, {30'h0, seed[1], ~seed[1] & seed[0]});
      rd("pull store", fopin_pkg::OFF_WAKE_PULL,
         {30'h0, seed[1], ~seed[1] & seed[0]});
      chk("pull held", 0, {pin_out.pull_up, pin_out.pull_down});
    end
    wr(fopin_pkg::OFF_IRQ_STAT, 32'h7);
    pin_level_in <= 1'b1;
    repeat (20) @(posedge pclk);
    rd("no wake", fopin_pkg::OFF_IRQ_STAT, 32'h0);
    pin_level_in <= 1'b0;
    repeat (20) @(posedge pclk);
    wr(fopin_pkg::OFF_MODE_REQ, 32'h1);
    chk("restart", 1, seen_restart);
    rd("sleep err", fopin_pkg::OFF_IRQ_STAT, 32'h1);
    wr(fopin_pkg::OFF_MEAS, 32'h0);
    repeat (2) @(posedge pclk);
    chk("pull apply", {seed[1], ~seed[1] & seed[0]},
        {pin_out.pull_up, pin_out.pull_down});
    wr(fopin_pkg::OFF_IRQ_STAT, 32'h7);
    pin_level_in <= 1'b1;
    repeat (2) @(posedge pclk);
    pin_level_in <= 1'b0;
    repeat (20) @(posedge pclk);
    rd("glitch", fopin_pkg::OFF_IRQ_STAT, 32'h0);
    pin_level_in <= 1'b1;
    repeat (20) @(posedge pclk);
    rd("wake", fopin_pkg::OFF_IRQ_STAT, 32'h2);
    chk("no wake normal", 0, seen_wake);
    wr(fopin_pkg::OFF_IRQ_STAT, 32'h7);
    wr(fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_LS});
    @(posedge pclk);
    chk("ls on", 1, pin_out.ls_on);
    overcurrent_in <= 1'b1;
    repeat (10) @(posedge pclk);
    overcurrent_in <= 1'b0;
    rd("oc off", fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_OFF});
    rd("oc flag", fopin_pkg::OFF_IRQ_STAT, 32'h4);
    wr(fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_HS});
    chip_mode <= fopin_pkg::FOPIN_STOP;
    wr(fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_LS});
    rd("stop fixed", fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_HS});
    chip_mode <= fopin_pkg::FOPIN_NORMAL;
    failure_entry <= 1'b1;
    @(posedge pclk);
    failure_entry <= 1'b0;
    rd("fail off", fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_OFF});
    wr(fopin_pkg::OFF_PIN_CFG, {28'h0, 1'b1, fopin_pkg::CFG_FAIL_OUT});
    @(posedge pclk);
    chk("test drive", 1, pin_out.fail_drive);
    chk("test not fail", 0, pin_active);
    wr(fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_FAIL_OUT});
    failure_entry <= 1'b1;
    @(posedge pclk);
    failure_entry <= 1'b0;
    repeat (3) @(posedge pclk);
    chk("fail active", 1, pin_active);
    wr(fopin_pkg::OFF_PIN_CFG, {29'h0, fopin_pkg::CFG_WAKE});
    chip_mode <= fopin_pkg::FOPIN_STOP;
    pin_level_in <= 1'b0;
    repeat (20) @(posedge pclk);
    chk("stop wake", 1, seen_wake);
    chip_mode <= fopin_pkg::FOPIN_NORMAL;
    rd("unmapped", 8'h1c, 32'h0);
    give_verdict();
  end
endmodule : tb_top
bind fopin_ctrl fopin_monitor #(.FILT(FILT)) fopin_monitor_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .chip_mode(chip_mode), .failure_entry(failure_entry),
  .other_wake_src(other_wake_src), .pin_level_in(pin_level_in),
  .overcurrent_in(overcurrent_in), .pin_out(pin_out),
  .pin_active(pin_active), .wake_to_chip(wake_to_chip),
  .go_restart(go_restart), .irq(irq));
